//--- shared/ascop_pkg.sv
// Constants and types for the angle sensor configuration and fuse port
// What this block does
// - Command 10111 writes control word; bit 15 sleeps, bit 14 global reset
// - Control bit 9 routes signal channels to the test bus after the amplifier
// - Control bit 8 disables and bypasses the output buffer for test
// - Extended mode holds each data bit for four serial clock periods
// - Extended 11111 writes image, 11001 burns fuses, 01111 reads image back
// - Lock bit 13 once burned blocks programming of factory bits 45 down to 14
// - Image bit 11 inverts sine and cosine ahead of the gain amplifier
// - Image bit 10 puts common mode on the negative sine pin
// - Image bit 9 puts common mode on the negative cosine pin
// - Image bits 8 and 7 set the two-bit amplifier gain
// - Image bit 6 picks output offset, 0 low level, 1 high level
// - Image bits 5 down to 0 set six-bit Hall bias
// - Upper image holds test fuse, part id, bias, reference and oscillator trims
// - Command 01001 presents one fuse level per four-clock data bit for analog check
// - Normal frame: five command bits then sixteen data bits, MSB first
// - Access starts at select rise; select low holds the interface in reset
// - Command bit 4 picks read or write, bit 3 normal or extended
// - Analog readback drives programming pin, starting with fuse bit 45
package ascop_pkg;

	// ----------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------
	localparam int             CMD_W       = 5;
	localparam int             NORM_W      = 16;
	localparam int             EXT_W       = 46;
	localparam int             CNT_W       = 6;
	localparam logic [CNT_W-1:0] CMD_LAST  = 6'h04;
	localparam logic [CNT_W-1:0] NORM_LAST = 6'h0f;
	localparam logic [CNT_W-1:0] EXT_LAST  = 6'h2d;
	localparam logic [1:0]     PHASE_LAST  = 2'h3;
	localparam int             CMD_BIT_WR  = 4;
	localparam int             CMD_BIT_EXT = 3;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [4:0] CMD_CTRL_WR = 5'h17;
	localparam logic [4:0] CMD_UNLOCK  = 5'h10;
	localparam logic [4:0] CMD_IMG_WR  = 5'h1f;
	localparam logic [4:0] CMD_BURN    = 5'h19;
	localparam logic [4:0] CMD_IMG_RD  = 5'h0f;
	localparam logic [4:0] CMD_ANA_RD  = 5'h09;
	localparam logic [15:0] UNLOCK_KEY = 16'h8cae;

	// ----------------------------------------------------------------
	// Image layout and reset values
	// ----------------------------------------------------------------
	localparam int          LOCK_POS     = 13;
	localparam logic [45:0] FACTORY_MASK = 46'h3fff_ffff_c000;
	localparam logic [45:0] IMG_RESET    = 46'h0;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;

	typedef struct packed {
		logic       low_power_request;
		logic       global_reset;
		logic [3:0] unused_hi;
		logic       test_bus_route;
		logic       output_buffer_skip;
		logic [7:0] unused_lo;
	} ascop_ctrl_type;

	typedef struct packed {
		logic [1:0]  otp_test;
		logic [17:0] part_id;
		logic [5:0]  bias_trim;
		logic [1:0]  vref_trim;
		logic [3:0]  osc_trim;
		logic        lock;
		logic        not_connected;
		logic        invert_channel;
		logic        sine_common_mode_enable;
		logic        cosine_common_mode_enable;
		logic [1:0]  gain;
		logic        output_level_select;
		logic [5:0]  hall_bias;
	} ascop_image_type;

	typedef enum logic [1:0] {
		LNK_CMD,
		LNK_DATA,
		LNK_DONE
	} ascop_link_state_type;

endpackage : ascop_pkg

//--- rtl/ascop_sync.sv
// Two-stage level synchroniser into the system clock
module ascop_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	// First stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= d_in;
			stage2_ff <= stage1_ff;
		end
	end

	assign q_out = stage2_ff;

endmodule : ascop_sync

//--- rtl/ascop_top.sv
// Serial command decoder, control word and fuse image store for one sensor die
module ascop_top (
	input  wire logic                      clk_in,
	input  wire logic                      rst_in,
	input  wire logic                      select_in,
	input  wire logic                      serial_clock_line_in,
	input  wire logic                      serial_data_line_in,
	output logic                           serial_data_line_out,
	output logic                           serial_data_line_oe_out,
	output logic                           programming_pin_out,
	output logic                           programming_pin_oe_out,
	output ascop_pkg::ascop_ctrl_type      control_out,
	output logic                           global_reset_out,
	output ascop_pkg::ascop_image_type     fuse_settings_out,
	output logic                           fuse_unlocked_out
);

	// ----------------------------------------------------------------
	// Link domain state
	// ----------------------------------------------------------------
	ascop_pkg::ascop_link_state_type state_ff;
	ascop_pkg::ascop_link_state_type nxt_state;
	logic [ascop_pkg::CNT_W-1:0]     cnt_ff;
	logic [ascop_pkg::CNT_W-1:0]     nxt_cnt;
	logic [1:0]                      phase_ff;
	logic [1:0]                      nxt_phase;
	logic [4:0]                      cmd_ff;
	logic [4:0]                      nxt_cmd;
	logic [45:0]                     shift_ff;
	logic [45:0]                     nxt_shift;
	logic [45:0]                     rd_shift_ff;
	logic [45:0]                     nxt_rd_shift;
	logic                            dio_out_ff;
	logic                            nxt_dio_out;
	logic                            dio_oe_ff;
	logic                            nxt_dio_oe;
	logic                            programming_pin_out_ff;
	logic                            nxt_programming_pin_out;
	logic                            programming_pin_oe_ff;
	logic                            nxt_programming_pin_oe;

	// Handed across with a toggle; held until the next write frame
	logic [4:0]                      xfer_cmd_ff;
	logic [4:0]                      nxt_xfer_cmd;
	logic [45:0]                     xfer_data_ff;
	logic [45:0]                     nxt_xfer_data;
	logic                            req_tog_ff;
	logic                            nxt_req_tog;

	// ----------------------------------------------------------------
	// System domain state
	// ----------------------------------------------------------------
	ascop_pkg::ascop_ctrl_type       ctrl_ff;
	ascop_pkg::ascop_ctrl_type       nxt_ctrl;
	logic                            grst_ff;
	logic                            nxt_grst;
	logic                            unlock_ff;
	logic                            nxt_unlock;
	logic [45:0]                     shadow_ff;
	logic [45:0]                     nxt_shadow;
	logic [45:0]                     fuse_ff;
	logic [45:0]                     nxt_fuse;
	ascop_pkg::ascop_image_type      eff_ff;
	ascop_pkg::ascop_image_type      nxt_eff;
	logic                            seen_ff;
	logic                            nxt_seen;
	logic                            sel_sync;
	logic                            tog_sync;

	// ----------------------------------------------------------------
	// Link domain next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [4:0]  cmd_full;
		logic        is_ext;
		logic        is_wr;
		logic        bit_end;
		logic [ascop_pkg::CNT_W-1:0] last;
		cmd_full      = {cmd_ff[3:0], serial_data_line_in};
		is_ext        = cmd_ff[ascop_pkg::CMD_BIT_EXT];
		is_wr         = cmd_ff[ascop_pkg::CMD_BIT_WR];
		bit_end       = !is_ext || (phase_ff == ascop_pkg::PHASE_LAST);
		last          = is_ext ? ascop_pkg::EXT_LAST : ascop_pkg::NORM_LAST;
		nxt_state     = state_ff;
		nxt_cnt       = cnt_ff;
		nxt_phase     = phase_ff;
		nxt_cmd       = cmd_ff;
		nxt_shift     = shift_ff;
		nxt_rd_shift  = rd_shift_ff;
		nxt_dio_out   = dio_out_ff;
		nxt_dio_oe    = dio_oe_ff;
		nxt_programming_pin_out  = programming_pin_out_ff;
		nxt_programming_pin_oe   = programming_pin_oe_ff;
		nxt_xfer_cmd  = xfer_cmd_ff;
		nxt_xfer_data = xfer_data_ff;
		nxt_req_tog   = req_tog_ff;
		unique case (state_ff)
			ascop_pkg::LNK_CMD: begin
				nxt_cmd = cmd_full;
				nxt_cnt = cnt_ff + 6'h01;
				if (cnt_ff == ascop_pkg::CMD_LAST) begin
					nxt_state = ascop_pkg::LNK_DATA;
					nxt_cnt   = '0;
					nxt_phase = '0;
					nxt_shift = '0;
					// Read direction chosen by command bit 4
					if (!cmd_full[ascop_pkg::CMD_BIT_WR]) begin
						if (cmd_full == ascop_pkg::CMD_ANA_RD) begin
							nxt_rd_shift = fuse_ff;
							nxt_programming_pin_oe  = 1'b1;
							nxt_programming_pin_out = fuse_ff[45];
						end else if (cmd_full[ascop_pkg::CMD_BIT_EXT]) begin
							nxt_rd_shift = eff_ff;
							nxt_dio_oe   = 1'b1;
							nxt_dio_out  = eff_ff[45];
						end else begin
							nxt_rd_shift = {ctrl_ff, 30'h0};
							nxt_dio_oe   = 1'b1;
							nxt_dio_out  = ctrl_ff[15];
						end
					end
				end
			end
			ascop_pkg::LNK_DATA: begin
				// Four clocks per bit in extended mode
				nxt_phase = is_ext ? phase_ff + 2'h1 : 2'h0;
				if (bit_end) begin
					nxt_shift    = {shift_ff[44:0], serial_data_line_in};
					nxt_rd_shift = {rd_shift_ff[44:0], 1'b0};
					nxt_dio_out  = dio_oe_ff & rd_shift_ff[44];
					nxt_programming_pin_out = programming_pin_oe_ff & rd_shift_ff[44];
					nxt_cnt      = cnt_ff + 6'h01;
					if (cnt_ff == last) begin
						nxt_state    = ascop_pkg::LNK_DONE;
						nxt_dio_oe   = 1'b0;
						nxt_dio_out  = 1'b0;
						nxt_programming_pin_oe  = 1'b0;
						nxt_programming_pin_out = 1'b0;
						if (is_wr) begin
							nxt_xfer_cmd  = cmd_ff;
							nxt_xfer_data = nxt_shift;
							nxt_req_tog   = ~req_tog_ff;
						end
					end
				end
			end
			ascop_pkg::LNK_DONE: begin
				// Extra clocks after the frame are ignored
				nxt_state = ascop_pkg::LNK_DONE;
			end
			default: begin
				nxt_state = ascop_pkg::LNK_CMD;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Link domain registers
	// ----------------------------------------------------------------
	// Select low clears the interface even with the link clock stopped
	always_ff @(posedge serial_clock_line_in or negedge select_in) begin
		if (!select_in) begin
			state_ff    <= ascop_pkg::LNK_CMD;
			cnt_ff      <= '0;
			phase_ff    <= '0;
			cmd_ff      <= '0;
			shift_ff    <= '0;
			rd_shift_ff <= '0;
			dio_out_ff  <= 1'b0;
			dio_oe_ff   <= 1'b0;
			programming_pin_out_ff <= 1'b0;
			programming_pin_oe_ff  <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			phase_ff    <= nxt_phase;
			cmd_ff      <= nxt_cmd;
			shift_ff    <= nxt_shift;
			rd_shift_ff <= nxt_rd_shift;
			dio_out_ff  <= nxt_dio_out;
			dio_oe_ff   <= nxt_dio_oe;
			programming_pin_out_ff <= nxt_programming_pin_out;
			programming_pin_oe_ff  <= nxt_programming_pin_oe;
		end
	end

	// Must survive select low, so only the system reset clears the toggle
	always_ff @(posedge serial_clock_line_in or posedge rst_in) begin
		if (rst_in) begin
			req_tog_ff   <= 1'b0;
			xfer_cmd_ff  <= '0;
			xfer_data_ff <= '0;
		end else begin
			req_tog_ff   <= nxt_req_tog;
			xfer_cmd_ff  <= nxt_xfer_cmd;
			xfer_data_ff <= nxt_xfer_data;
		end
	end

	// ----------------------------------------------------------------
	// Crossing into the system clock
	// ----------------------------------------------------------------
	ascop_sync #(
		.WIDTH (2)
	) u_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({select_in, req_tog_ff}),
		.q_out  ({sel_sync, tog_sync})
	);

	// ----------------------------------------------------------------
	// Command execution, system domain
	// ----------------------------------------------------------------
	always_comb begin
		logic        evt;
		logic [45:0] wmask;
		evt        = tog_sync != seen_ff;
		// Locked factory bits are never written or burned
		wmask      = fuse_ff[ascop_pkg::LOCK_POS] ? ~ascop_pkg::FACTORY_MASK : '1;
		nxt_seen   = tog_sync;
		nxt_ctrl   = ctrl_ff;
		nxt_grst   = 1'b0;
		nxt_unlock = unlock_ff;
		nxt_shadow = shadow_ff;
		nxt_fuse   = fuse_ff;
		if (evt) begin
			unique case (xfer_cmd_ff)
				ascop_pkg::CMD_CTRL_WR: begin
					nxt_ctrl = xfer_data_ff[15:0];
					nxt_grst = xfer_data_ff[14];
				end
				ascop_pkg::CMD_UNLOCK: begin
					if (xfer_data_ff[15:0] == ascop_pkg::UNLOCK_KEY) begin
						nxt_unlock = 1'b1;
					end
				end
				ascop_pkg::CMD_IMG_WR: begin
					if (unlock_ff) begin
						nxt_shadow = (xfer_data_ff & wmask) | (shadow_ff & ~wmask);
					end
				end
				ascop_pkg::CMD_BURN: begin
					// Fuses only ever go from unburned to burned
					if (unlock_ff) begin
						nxt_fuse = fuse_ff | (xfer_data_ff & wmask);
					end
				end
				default: begin
					nxt_ctrl = ctrl_ff;
				end
			endcase
		end
		if (nxt_grst) begin
			nxt_unlock = 1'b0;
			nxt_shadow = ascop_pkg::IMG_RESET;
		end
		if (!sel_sync) begin
			nxt_ctrl = ascop_pkg::CTRL_RESET;
		end
		// Effective settings: burned fuses plus the trial image
		nxt_eff = nxt_fuse | nxt_shadow;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_ff   <= ascop_pkg::CTRL_RESET;
			grst_ff   <= 1'b0;
			unlock_ff <= 1'b0;
			shadow_ff <= ascop_pkg::IMG_RESET;
			fuse_ff   <= ascop_pkg::IMG_RESET;
			eff_ff    <= ascop_pkg::IMG_RESET;
			seen_ff   <= 1'b0;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			grst_ff   <= nxt_grst;
			unlock_ff <= nxt_unlock;
			shadow_ff <= nxt_shadow;
			fuse_ff   <= nxt_fuse;
			eff_ff    <= nxt_eff;
			seen_ff   <= nxt_seen;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Sleep, test bus and buffer skip bits drive the analog path
	assign control_out             = ctrl_ff;
	assign global_reset_out        = grst_ff;
	// Polarity, common mode, gain, offset and bias fields
	assign fuse_settings_out       = eff_ff;
	assign fuse_unlocked_out       = unlock_ff;
	assign serial_data_line_out    = dio_out_ff;
	assign serial_data_line_oe_out = dio_oe_ff;
	assign programming_pin_out     = programming_pin_out_ff;
	assign programming_pin_oe_out  = programming_pin_oe_ff;

endmodule : ascop_top

//--- tb/ascop_top_sva.sv
// Concurrent checks on the configuration and fuse port
module ascop_top_sva (
	input wire logic                       clk_in,
	input wire logic                       rst_in,
	input wire logic                       select_in,
	input wire logic                       serial_clock_line_in,
	input wire logic                       serial_data_line_in,
	input wire logic                       serial_data_line_out,
	input wire logic                       serial_data_line_oe_out,
	input wire logic                       programming_pin_out,
	input wire logic                       programming_pin_oe_out,
	input wire ascop_pkg::ascop_ctrl_type  control_out,
	input wire logic                       global_reset_out,
	input wire ascop_pkg::ascop_image_type fuse_settings_out,
	input wire logic                       fuse_unlocked_out
);
	// ----------
	// Frame tracking
	// ----------
	logic [7:0] cnt_ff;
	logic [4:0] cmd_ff;
	logic       rd_win;
	// Async clear mirrors the link reset on select low
	always_ff @(posedge serial_clock_line_in or negedge select_in) begin
		if (!select_in) begin
			cnt_ff <= 8'h00;
			cmd_ff <= 5'h00;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
			if (cnt_ff < 8'h05) begin
				cmd_ff <= {cmd_ff[3:0], serial_data_line_in};
			end
		end
	end
	assign rd_win = cnt_ff > 8'h04 && cnt_ff <= (cmd_ff[3] ? 8'hbc : 8'h14);
	// ----------
	// Assertions
	// ----------
	a_read_drives_line: assert property (
		@(posedge serial_clock_line_in) disable iff (!select_in)
		rd_win && (cmd_ff[4:3] == 2'h0 || cmd_ff == 5'h0f) |-> serial_data_line_oe_out)
		else $error("data line not driven in read");
	a_ext_bit_hold: assert property (
		@(posedge serial_clock_line_in) disable iff (!select_in)
		serial_data_line_oe_out && cmd_ff[3] && cnt_ff > 8'h05 && cnt_ff[1:0] != 2'h1
		|-> $stable(serial_data_line_out))
		else $error("read bit changed inside phase");
	a_fuse_pin_drive: assert property (
		@(posedge serial_clock_line_in) disable iff (!select_in)
		rd_win && cmd_ff == 5'h09 |-> programming_pin_oe_out)
		else $error("fuse pin not driven in readback");
	a_deselect_quiet: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!select_in |-> !serial_data_line_oe_out && !programming_pin_oe_out)
		else $error("outputs driven while deselected");
	a_ctrl_clears: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!select_in [*6] |-> control_out == 16'h0000)
		else $error("control word kept while deselected");
	// No disable here: the reset itself is the cause under test
	a_reset_clean: assert property (
		@(posedge clk_in) rst_in [*3] |=> control_out == 16'h0000 && !fuse_unlocked_out
		&& !global_reset_out && fuse_settings_out == 46'h0)
		else $error("outputs not cleared by reset");
	a_reset_pulse_single: assert property (
		@(posedge clk_in) disable iff (rst_in)
		global_reset_out |=> !global_reset_out)
		else $error("global reset longer than one cycle");
	a_unlock_gates_image: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!fuse_unlocked_out [*6] |-> $stable(fuse_settings_out))
		else $error("image changed while not unlocked");
	// Only new ones are banned; a global reset may still clear bits
	a_lock_holds_trim: assert property (
		@(posedge clk_in) disable iff (rst_in)
		fuse_settings_out[13] && $past(fuse_settings_out[13])
		|-> (fuse_settings_out[45:14] & ~$past(fuse_settings_out[45:14])) == 32'h0)
		else $error("factory bits set while locked");
	c_ext_read: cover property (@(posedge serial_clock_line_in) cnt_ff == 8'hbc && cmd_ff == 5'h0f);
	c_global_reset: cover property (@(posedge clk_in) global_reset_out);
	c_locked: cover property (@(posedge clk_in) fuse_settings_out[13]);
endmodule : ascop_top_sva

bind ascop_top ascop_top_sva u_sva (.*);

//--- tb/ascop_master_model.sv
// Serial configuration master model for the three-wire link
module ascop_master_model (
	output logic      select_out,
	output logic      sclk_out,
	output logic      sdata_out,
	output logic      sdata_oe_out,
	input  wire logic sdata_in,
	input  wire logic programming_pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// Real falling select after time zero, so the async link clear always fires
	initial begin
		select_out = 1'b1;
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		sdata_oe_out = 1'b0;
		#1 select_out = 1'b0;
	end
	// One bit: clock idles low, lines sampled just before the rise
	task automatic tick(input logic b, output logic r, output logic g);
		sdata_out = b;
		#16;
		r = sdata_in;
		g = programming_pin_in;
		sclk_out = 1'b1;
		#16 sclk_out = 1'b0;
	endtask : tick
	task automatic frame(input logic [4:0] cmd, input logic [45:0] dat,
	                     output logic [45:0] rd, output logic [45:0] pg);
		logic r;
		logic g;
		rd = 46'h0;
		pg = 46'h0;
		select_out = 1'b0;
		#63 select_out = 1'b1;
		#20 sdata_oe_out = 1'b1;
		for (int c = 4; c >= 0; c--) begin
			tick(cmd[c], r, g);
		end
		// Read frames hand the line to the device
		sdata_oe_out = cmd[4];
		for (int i = (cmd[3] ? 45 : 15); i >= 0; i--) begin
			for (int p = 0; p < (cmd[3] ? 4 : 1); p++) begin
				tick(dat[i], rd[i], pg[i]);
			end
		end
		#20 sdata_oe_out = 1'b0;
	endtask : frame
endmodule : ascop_master_model

//--- tb/tb_top.sv
// Self-checking bench for the configuration and fuse port
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [45:0] V1  = 46'h3a5c_3c96_c5a7;
	localparam logic [45:0] BRN = 46'h0001_0000_2000;
	logic                       clk_in;
	logic                       rst_in;
	logic                       select_in;
	logic                       serial_clock_line_in;
	logic                       serial_data_line_in;
	logic                       serial_data_line_out;
	logic                       serial_data_line_oe_out;
	logic                       programming_pin_out;
	logic                       programming_pin_oe_out;
	ascop_pkg::ascop_ctrl_type  control_out;
	logic                       global_reset_out;
	ascop_pkg::ascop_image_type fuse_settings_out;
	logic                       fuse_unlocked_out;
	logic                       m_d;
	logic                       m_oe;
	logic                       pgw;
	logic                       pat = 1'b0;
	logic [45:0]                rd;
	logic [45:0]                pg;
	int                         err_count = 0;
	int                         cmp_count = 0;
	int                         gr_count = 0;
	// Released lines toggle, so a stale value never passes
	assign serial_data_line_in = serial_data_line_oe_out ? serial_data_line_out : (m_oe ? m_d : pat);
	assign pgw = programming_pin_oe_out ? programming_pin_out : pat;
	ascop_top dut (.*);
	ascop_master_model ctl (
		.select_out  (select_in),
		.sclk_out    (serial_clock_line_in),
		.sdata_out   (m_d),
		.sdata_oe_out(m_oe),
		.sdata_in    (serial_data_line_in),
		.programming_pin_in     (pgw)
	);
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		pat <= ~pat;
		if (global_reset_out === 1'b1) begin
			gr_count <= gr_count + 1;
		end
	end
	task automatic check(input logic [45:0] seen, input logic [45:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	task automatic xfer(input logic [4:0] c, input logic [45:0] d);
		ctl.frame(c, d, rd, pg);
	endtask : xfer
	// Write effects land within a few cycles
	task automatic settle();
		repeat (10) @(negedge clk_in);
	endtask : settle
	task automatic t_unlock();
		xfer(ascop_pkg::CMD_UNLOCK, 46'h8cad);
		settle();
		check({45'h0, fuse_unlocked_out}, 46'h0);
		xfer(ascop_pkg::CMD_IMG_WR, V1);
		settle();
		check(fuse_settings_out, 46'h0);
		xfer(ascop_pkg::CMD_UNLOCK, {30'h0, ascop_pkg::UNLOCK_KEY});
		settle();
		check({45'h0, fuse_unlocked_out}, 46'h1);
	endtask : t_unlock
	task automatic t_image();
		xfer(ascop_pkg::CMD_IMG_WR, V1);
		settle();
		check(fuse_settings_out, V1);
		xfer(ascop_pkg::CMD_IMG_RD, 46'h0);
		check(rd, V1);
	endtask : t_image
	task automatic t_burn();
		xfer(ascop_pkg::CMD_BURN, BRN);
		settle();
		check(fuse_settings_out, V1 | BRN);
		xfer(ascop_pkg::CMD_ANA_RD, 46'h0);
		check(pg, BRN);
		xfer(ascop_pkg::CMD_IMG_WR, 46'h3fff_ffff_ffff);
		settle();
		check(fuse_settings_out, BRN | (V1 & ascop_pkg::FACTORY_MASK) | 46'h3fff);
	endtask : t_burn
	task automatic t_ctrl();
		xfer(ascop_pkg::CMD_CTRL_WR, 46'hc300);
		settle();
		check({30'h0, control_out}, 46'hc300);
		check(46'(gr_count), 46'h1);
		check({45'h0, fuse_unlocked_out}, 46'h0);
		check(fuse_settings_out, BRN);
		xfer(5'h07, 46'h0);
		check({30'h0, control_out}, 46'h0);
		check(rd, 46'h0);
	endtask : t_ctrl
	// Rising reset after time zero, so the async toggle clear always fires
	initial begin
		rst_in = 1'b0;
		#1 rst_in = 1'b1;
		repeat (16) @(negedge clk_in);
		rst_in = 1'b0;
		check(fuse_settings_out, 46'h0);
		check({30'h0, control_out}, 46'h0);
		t_unlock();
		t_image();
		t_burn();
		t_ctrl();
		results();
	end
	initial begin
		repeat (100000) @(posedge clk_in);
		err_count++;
		results();
	end
endmodule : tb_top
